//--- lds_i2c_master.sv
// bus master model that drives the serial link of the led driver
`timescale 1ns/100ps
module lds_i2c_master (
    input  wire logic       clk_sys,
    input  wire logic       sda_in,
    output logic            scl = 1'b1,
    output logic            sda = 1'b1,
    output logic            rd_valid = 1'b0,
    output logic [7:0]      rd_data = 8'h00
);
    // a quarter bit of eight link cycles leaves room for the sync and filter delay
    task automatic step(input logic c, input logic d);
        scl = c;
        sda = d;
        repeat (32) @(negedge clk_sys);
    endtask
    // data only moves while the clock is low
    task automatic bit_io(input logic b, output logic r);
        step(1'b0, b);
        step(1'b1, b);
        r = sda_in;
        step(1'b1, b);
        step(1'b0, b);
    endtask
    task automatic start();
        step(scl, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r); // line released for the ninth pulse
        ack = ~r;
    endtask
    // a nack on the last byte ends the read
    task automatic rbyte(input logic last);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, rd_data[i]);
        bit_io(last, r);
        rd_valid = 1'b1;
        @(negedge clk_sys);
        rd_valid = 1'b0;
    endtask
endmodule

//--- lds_pkg.sv
// package of constants for the led driver serial slave port
package lds_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] LDS_REG_IN_LO     = 4'h0;
    localparam logic [3:0] LDS_REG_IN_HI     = 4'h1;
    localparam logic [3:0] LDS_REG_A_PRE     = 4'h2;
    localparam logic [3:0] LDS_REG_A_DUTY    = 4'h3;
    localparam logic [3:0] LDS_REG_B_PRE     = 4'h4;
    localparam logic [3:0] LDS_REG_B_DUTY    = 4'h5;
    localparam logic [3:0] LDS_REG_SEL0      = 4'h6;
    localparam logic [3:0] LDS_REG_LAST      = 4'h9;
    localparam logic [3:0] LDS_REG_FIRST     = 4'h0;
    localparam logic [3:0] LDS_REG_WR_FIRST  = 4'h2;
    localparam logic [7:0] LDS_PRE_RESET     = 8'h00;
    localparam logic [7:0] LDS_DUTY_RESET    = 8'h80;
    localparam logic [7:0] LDS_SEL_RESET     = 8'h00;
    // ------------------------------------------------------------
    // address and register-address byte fields
    // ------------------------------------------------------------
    localparam logic [3:0] LDS_ADDR_FIXED    = 4'h6;
    localparam int         LDS_AI_BIT        = 4;
    localparam int         LDS_DIR_BIT       = 0;
    // ------------------------------------------------------------
    // selector codes
    // ------------------------------------------------------------
    localparam logic [1:0] LDS_SEL_OFF       = 2'h0;
    localparam logic [1:0] LDS_SEL_ON        = 2'h1;
    localparam logic [1:0] LDS_SEL_RATE_A    = 2'h2;
    localparam logic [1:0] LDS_SEL_RATE_B    = 2'h3;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int LDS_LINK_PERIOD_NS  = 160;
    localparam int LDS_SPIKE_NS        = 50;
    localparam int LDS_FILT_CYC        = (LDS_SPIKE_NS + LDS_LINK_PERIOD_NS - 1)
                                         / LDS_LINK_PERIOD_NS;
    localparam int LDS_SYS_PERIOD_NS   = 40;
    localparam int LDS_RST_PULSE_NS    = 10;
    localparam int LDS_RST_CYC         = (LDS_RST_PULSE_NS + LDS_SYS_PERIOD_NS - 1)
                                         / LDS_SYS_PERIOD_NS;
    localparam int LDS_TICK_DIV        = 156;
    typedef enum logic [2:0] {
        LDS_IDLE, LDS_ADDR, LDS_REGADDR, LDS_WDATA, LDS_RDATA, LDS_ACK, LDS_RACK
    } lds_state_e;
endpackage

//--- lds_rate_gen.sv
// one programmable blink rate generator
`timescale 1ns/100ps
module lds_rate_gen
    import lds_pkg::*;
#(
    parameter int DIV = LDS_TICK_DIV
)
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic [7:0] prescale,
    input  wire logic [7:0] duty,
    output logic            dim_on
);
    if (DIV < 1 || DIV > 65536)
    begin : g_bad_div
        $error("DIV must be 1 to 65536");
    end
    logic [15:0] tick_reg;
    logic [7:0]  pre_reg;
    logic [7:0]  phase_reg;
    logic        tick;
    assign tick = (tick_reg == 16'(DIV - 1));
    // ------------------------------------------------------------
    // tick, prescale and phase counters
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (reset || tick)
            tick_reg <= 16'h0000;
        else
            tick_reg <= tick_reg + 16'h0001;
    end
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pre_reg   <= 8'h00;
            phase_reg <= 8'h00;
        end
        else if (tick)
        begin
            if (pre_reg >= prescale)
            begin
                pre_reg   <= 8'h00;
                phase_reg <= phase_reg + 8'h01;
            end
            else
                pre_reg <= pre_reg + 8'h01;
        end
    end
    // led on while phase below duty; duty 0 keeps it off
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            dim_on <= 1'b0;
        else
            dim_on <= (phase_reg < duty);
    end
endmodule

//--- lds_top.sv
// serial slave port and led control of the 16-channel led driver
`timescale 1ns/100ps
// What this block does
// RULE1: power-on reset loads default register values
// RULE2: low reset pin restores defaults
// RULE3: data changes only while clock low
// RULE4: detect start and stop with clock high
// RULE5: bus busy from start until stop
// RULE6: repeated start restarts address reception
// RULE7: eight-bit bytes, most significant first
// RULE8: unlimited bytes per transfer
// RULE9: ninth clock carries the acknowledge
// RULE10: address byte fixed upper, pins select lower
// RULE11: direction zero writes, one reads
// RULE12: write: address, register address, data
// RULE13: read preceded by write addressing phase
// RULE14: increment bit enables sequential addressing
// RULE15: master sends zero in bits seven-five
// RULE16: read increment wraps nine to zero
// RULE17: write increment wraps nine to two
// RULE18: read-only writes acknowledged then discarded
// RULE19: no increment repeats the same register
// RULE20: each led on, off, rate a, b
// RULE21: two independent prescale and duty generators
// RULE22: two read-only registers report pin state
// RULE23: zero-one read-only, two-nine read-write
// RULE24: selector codes off, on, rate a, b
// RULE25: increment bit four, index bits three-zero
// RULE26: input filter suppresses short spikes
module lds_top
    import lds_pkg::*;
#(
    parameter int FILT = LDS_FILT_CYC
)
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        reset_pin_n,
    input  wire logic        clk_link,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n,
    input  wire logic        slave_addr_sel_lsb,
    input  wire logic        slave_addr_sel_mid,
    input  wire logic        slave_addr_sel_msb,
    input  wire logic [15:0] led_i,
    output logic      [15:0] led_o,
    output logic      [15:0] led_oe_n,
    output logic             bus_busy
);
    if (FILT < 1 || FILT > 8)
    begin : g_bad_filt
        $error("FILT out of range");
    end

    // ------------------------------------------------------------
    // reset: internal power-on reset plus synchronised pin
    // ------------------------------------------------------------
    logic rpin_s1_reg, rpin_s2_reg, dev_rst_reg;
    always_ff @(posedge clk_sys)
    begin
        rpin_s1_reg <= reset_pin_n;
        rpin_s2_reg <= rpin_s1_reg;
    end
    always_ff @(posedge clk_sys)
    begin
        dev_rst_reg <= reset | ~rpin_s2_reg; // [RULE1] [RULE2]
    end
    // link-side reset crosses as a level
    logic lrst_s1_reg, lrst_s2_reg;
    always_ff @(posedge clk_link)
    begin
        lrst_s1_reg <= dev_rst_reg;
        lrst_s2_reg <= lrst_s1_reg;
    end

    // ------------------------------------------------------------
    // link inputs: synchroniser then spike filter
    // ------------------------------------------------------------
    logic [1:0] sc_s1_reg, sc_s2_reg;
    logic [2:0] scl_cnt_reg, sda_cnt_reg;
    logic       scl_f_reg, sda_f_reg, scl_d_reg, sda_d_reg;
    always_ff @(posedge clk_link)
    begin
        sc_s1_reg <= {scl_i, sda_i};
        sc_s2_reg <= sc_s1_reg;
    end
    // a level must hold FILT samples before it is believed
    always_ff @(posedge clk_link)
    begin
        if (lrst_s2_reg)
        begin
            scl_cnt_reg <= 3'h0;
            sda_cnt_reg <= 3'h0;
            scl_f_reg   <= 1'b1;
            sda_f_reg   <= 1'b1;
        end
        else
        begin
            if (sc_s2_reg[1] == scl_f_reg)
                scl_cnt_reg <= 3'h0;
            else if (scl_cnt_reg == 3'(FILT - 1))
            begin
                scl_f_reg   <= sc_s2_reg[1]; // [RULE26]
                scl_cnt_reg <= 3'h0;
            end
            else
                scl_cnt_reg <= scl_cnt_reg + 3'h1;
            if (sc_s2_reg[0] == sda_f_reg)
                sda_cnt_reg <= 3'h0;
            else if (sda_cnt_reg == 3'(FILT - 1))
            begin
                sda_f_reg   <= sc_s2_reg[0]; // [RULE26]
                sda_cnt_reg <= 3'h0;
            end
            else
                sda_cnt_reg <= sda_cnt_reg + 3'h1;
        end
    end
    always_ff @(posedge clk_link)
    begin
        scl_d_reg <= scl_f_reg;
        sda_d_reg <= sda_f_reg;
    end
    logic start_det, stop_det, scl_rise, scl_fall;
    assign start_det = scl_f_reg & scl_d_reg & sda_d_reg & ~sda_f_reg; // [RULE4]
    assign stop_det  = scl_f_reg & scl_d_reg & ~sda_d_reg & sda_f_reg; // [RULE4]
    assign scl_rise  = scl_f_reg & ~scl_d_reg;
    assign scl_fall  = ~scl_f_reg & scl_d_reg;

    // ------------------------------------------------------------
    // register file (system domain), read through a snapshot
    // ------------------------------------------------------------
    logic [7:0] regs_reg [2:9];
    logic [7:0] pins_reg [0:1];
    logic [15:0] led_s1_reg, led_s2_reg;
    always_ff @(posedge clk_sys)
    begin
        led_s1_reg <= led_i;
        led_s2_reg <= led_s1_reg;
    end
    always_ff @(posedge clk_sys)
    begin
        pins_reg[0] <= led_s2_reg[7:0];  // [RULE22]
        pins_reg[1] <= led_s2_reg[15:8]; // [RULE22]
    end

    function automatic logic [3:0] next_index(input logic [3:0] idx, input logic wr);
        if (idx >= LDS_REG_LAST)
            next_index = wr ? LDS_REG_WR_FIRST : LDS_REG_FIRST; // [RULE16] [RULE17]
        else
            next_index = idx + 4'h1;
    endfunction

    // ------------------------------------------------------------
    // link state machine
    // ------------------------------------------------------------
    lds_state_e state_reg, ret_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_reg;
    logic [3:0] idx_reg;
    logic       ai_reg, ack_drive_reg, out_bit_reg;
    logic       wr_tog_reg;
    logic [3:0] wr_idx_reg;
    logic [7:0] wr_dat_reg;
    logic [7:0] rd_byte;
    logic [6:0] my_addr;
    logic [7:0] rx_byte;
    logic [2:0] asel_s1_reg, asel_s2_reg;
    // straps are pins too, so they pass the same two flops as the link lines
    always_ff @(posedge clk_link)
    begin
        asel_s1_reg <= {slave_addr_sel_msb, slave_addr_sel_mid, slave_addr_sel_lsb};
        asel_s2_reg <= asel_s1_reg;
    end
    assign my_addr = {LDS_ADDR_FIXED, asel_s2_reg}; // [RULE10]
    assign rx_byte = {shift_reg[6:0], sda_f_reg};
    // register words are quasi-static; a read samples them at the byte boundary
    always_comb
    begin
        if (idx_reg <= LDS_REG_IN_HI)
            rd_byte = pins_reg[idx_reg[0]];
        else if (idx_reg <= LDS_REG_LAST)
            rd_byte = regs_reg[idx_reg];
        else
            rd_byte = 8'h00;
    end

    always_ff @(posedge clk_link)
    begin
        if (lrst_s2_reg)
        begin
            state_reg     <= LDS_IDLE;
            ret_reg       <= LDS_IDLE;
            shift_reg     <= 8'h00;
            bit_reg       <= 4'h0;
            idx_reg       <= 4'h0;
            ai_reg        <= 1'b0;
            ack_drive_reg <= 1'b0;
            out_bit_reg   <= 1'b1;
            wr_tog_reg    <= 1'b0;
            wr_idx_reg    <= 4'h0;
            wr_dat_reg    <= 8'h00;
            bus_busy      <= 1'b0;
        end
        else if (start_det)
        begin
            state_reg     <= LDS_ADDR; // [RULE6]
            bit_reg       <= 4'h0;
            ack_drive_reg <= 1'b0;
            out_bit_reg   <= 1'b1;
            bus_busy      <= 1'b1; // [RULE5]
        end
        else if (stop_det)
        begin
            state_reg     <= LDS_IDLE;
            ack_drive_reg <= 1'b0;
            out_bit_reg   <= 1'b1;
            bus_busy      <= 1'b0; // [RULE5]
        end
        else
        begin
            unique case (state_reg)
                LDS_IDLE: ;
                LDS_ADDR, LDS_REGADDR, LDS_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shift_reg <= rx_byte; // [RULE7]
                        bit_reg   <= bit_reg + 4'h1;
                    end
                    if (scl_fall && bit_reg == 4'h8)
                    begin
                        bit_reg <= 4'h0;
                        if (state_reg == LDS_ADDR)
                        begin
                            if (shift_reg[7:1] == my_addr)
                            begin
                                ack_drive_reg <= 1'b1; // [RULE9]
                                ret_reg       <= shift_reg[LDS_DIR_BIT] ? LDS_RDATA // [RULE11]
                                                                        : LDS_REGADDR;
                                state_reg     <= LDS_ACK;
                            end
                            else
                                state_reg <= LDS_IDLE;
                        end
                        else if (state_reg == LDS_REGADDR)
                        begin
                            ai_reg        <= shift_reg[LDS_AI_BIT]; // [RULE14] [RULE25]
                            idx_reg       <= shift_reg[3:0]; // [RULE25] [RULE12]
                            ack_drive_reg <= 1'b1;
                            ret_reg       <= LDS_WDATA;
                            state_reg     <= LDS_ACK;
                        end
                        else
                        begin
                            // read-only and unmapped targets are acked and dropped
                            if (idx_reg >= LDS_REG_A_PRE && idx_reg <= LDS_REG_LAST)
                            begin
                                wr_idx_reg <= idx_reg; // [RULE18] [RULE23]
                                wr_dat_reg <= shift_reg;
                                wr_tog_reg <= ~wr_tog_reg;
                            end
                            if (ai_reg)
                                idx_reg <= next_index(idx_reg, 1'b1); // [RULE17]
                            ack_drive_reg <= 1'b1; // [RULE8] [RULE19]
                            ret_reg       <= LDS_WDATA;
                            state_reg     <= LDS_ACK;
                        end
                    end
                end
                LDS_ACK:
                begin
                    // release on the falling edge closing the ninth pulse
                    if (scl_fall)
                    begin
                        ack_drive_reg <= 1'b0;
                        state_reg     <= ret_reg;
                        if (ret_reg == LDS_RDATA)
                        begin
                            shift_reg   <= {rd_byte[6:0], 1'b1};
                            out_bit_reg <= rd_byte[7]; // [RULE3] [RULE7]
                            bit_reg     <= 4'h1;
                        end
                    end
                end
                LDS_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (bit_reg == 4'h8)
                        begin
                            out_bit_reg <= 1'b1; // [RULE9]
                            state_reg   <= LDS_RACK;
                            if (ai_reg)
                                idx_reg <= next_index(idx_reg, 1'b0); // [RULE16]
                        end
                        else
                        begin
                            out_bit_reg <= shift_reg[7]; // [RULE3]
                            shift_reg   <= {shift_reg[6:0], 1'b1};
                            bit_reg     <= bit_reg + 4'h1;
                        end
                    end
                end
                LDS_RACK:
                begin
                    if (scl_rise)
                        ret_reg <= sda_f_reg ? LDS_IDLE : LDS_RDATA;
                    if (scl_fall)
                    begin
                        state_reg <= ret_reg;
                        if (ret_reg == LDS_RDATA)
                        begin
                            shift_reg   <= {rd_byte[6:0], 1'b1};
                            out_bit_reg <= rd_byte[7];
                            bit_reg     <= 4'h1;
                        end
                    end
                end
                default: state_reg <= LDS_IDLE;
            endcase
        end
    end
    // open drain: enable low drives the line low
    always_ff @(posedge clk_link)
    begin
        sda_o    <= 1'b0;
        sda_oe_n <= lrst_s2_reg ? 1'b1 : ~(ack_drive_reg | ~out_bit_reg); // [RULE9]
    end

    // ------------------------------------------------------------
    // write toggle crosses into the system domain
    // ------------------------------------------------------------
    logic tg_s1_reg, tg_s2_reg, tg_s3_reg;
    always_ff @(posedge clk_sys)
    begin
        tg_s1_reg <= wr_tog_reg;
        tg_s2_reg <= tg_s1_reg;
        tg_s3_reg <= tg_s2_reg;
    end
    // index and data are stable for many link cycles after the toggle
    always_ff @(posedge clk_sys)
    begin
        if (dev_rst_reg)
        begin
            regs_reg[LDS_REG_A_PRE]  <= LDS_PRE_RESET; // [RULE1]
            regs_reg[LDS_REG_A_DUTY] <= LDS_DUTY_RESET;
            regs_reg[LDS_REG_B_PRE]  <= LDS_PRE_RESET;
            regs_reg[LDS_REG_B_DUTY] <= LDS_DUTY_RESET;
            for (int i = LDS_REG_SEL0; i <= LDS_REG_LAST; i++)
                regs_reg[i] <= LDS_SEL_RESET;
        end
        // a link-side reset can flip the toggle late; its index 0 must not land
        else if (tg_s2_reg != tg_s3_reg && wr_idx_reg >= LDS_REG_A_PRE)
            regs_reg[wr_idx_reg] <= wr_dat_reg; // [RULE23]
    end

    // ------------------------------------------------------------
    // rate generators and led outputs
    // ------------------------------------------------------------
    logic blink_rate_a, blink_rate_b;
    lds_rate_gen #(.DIV(LDS_TICK_DIV)) u_rate_a (
        .clk_sys  (clk_sys),
        .reset    (dev_rst_reg),
        .prescale (regs_reg[LDS_REG_A_PRE]),
        .duty     (regs_reg[LDS_REG_A_DUTY]),
        .dim_on   (blink_rate_a)
    ); // [RULE21]
    lds_rate_gen #(.DIV(LDS_TICK_DIV)) u_rate_b (
        .clk_sys  (clk_sys),
        .reset    (dev_rst_reg),
        .prescale (regs_reg[LDS_REG_B_PRE]),
        .duty     (regs_reg[LDS_REG_B_DUTY]),
        .dim_on   (blink_rate_b)
    ); // [RULE21]
    generate
        for (genvar g = 0; g < 16; g++)
        begin : g_led
            logic [1:0] sel;
            assign sel = regs_reg[LDS_REG_SEL0 + g / 4][2 * (g % 4) +: 2];
            always_ff @(posedge clk_sys)
            begin
                led_o[g] <= 1'b0;
                if (dev_rst_reg)
                    led_oe_n[g] <= 1'b1;
                else
                    unique case (sel)
                        LDS_SEL_OFF:    led_oe_n[g] <= 1'b1; // [RULE24] [RULE20]
                        LDS_SEL_ON:     led_oe_n[g] <= 1'b0; // [RULE24]
                        LDS_SEL_RATE_A: led_oe_n[g] <= ~blink_rate_a; // [RULE24]
                        LDS_SEL_RATE_B: led_oe_n[g] <= ~blink_rate_b; // [RULE24]
                    endcase
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_busy_start: assert property ( // [RULE5]
        @(posedge clk_link) disable iff (lrst_s2_reg) start_det |=> bus_busy)
        else $error("busy not set by start");
    chk_busy_stop: assert property ( // [RULE5]
        @(posedge clk_link) disable iff (lrst_s2_reg) stop_det |=> !bus_busy)
        else $error("busy not cleared by stop");
    chk_restart_addr: assert property ( // [RULE6]
        @(posedge clk_link) disable iff (lrst_s2_reg) start_det |=> state_reg == LDS_ADDR)
        else $error("start not restart");
    chk_sda_stable: assert property ( // [RULE3]
        @(posedge clk_link) disable iff (lrst_s2_reg)
        (scl_f_reg && scl_d_reg && !start_det && !stop_det) |=> $stable(out_bit_reg))
        else $error("data changed while clock high");
    chk_ack_drive: assert property ( // [RULE9]
        @(posedge clk_link) disable iff (lrst_s2_reg) state_reg == LDS_ACK |-> ack_drive_reg)
        else $error("ack not driven");
    chk_wrap_wr: assert property ( // [RULE17]
        @(posedge clk_link) disable iff (lrst_s2_reg)
        (state_reg == LDS_WDATA && scl_fall && bit_reg == 4'h8 && ai_reg
         && idx_reg == LDS_REG_LAST && !start_det && !stop_det)
        |=> idx_reg == LDS_REG_WR_FIRST) else $error("write wrap wrong");
    chk_wrap_rd: assert property ( // [RULE16]
        @(posedge clk_link) disable iff (lrst_s2_reg)
        (state_reg == LDS_RDATA && scl_fall && bit_reg == 4'h8 && ai_reg
         && idx_reg == LDS_REG_LAST && !start_det && !stop_det)
        |=> idx_reg == LDS_REG_FIRST) else $error("read wrap wrong");
    chk_ro_drop: assert property ( // [RULE18]
        @(posedge clk_link) disable iff (lrst_s2_reg)
        (state_reg == LDS_WDATA && idx_reg <= LDS_REG_IN_HI) |=> $stable(wr_tog_reg))
        else $error("read-only write passed");
    chk_led_on: assert property ( // [RULE24]
        @(posedge clk_sys) disable iff (dev_rst_reg)
        regs_reg[LDS_REG_SEL0][5:4] == LDS_SEL_ON |=> !led_oe_n[2])
        else $error("led on wrong");
    cov_write: cover property (@(posedge clk_link) state_reg == LDS_WDATA && scl_fall);
    cov_read: cover property (@(posedge clk_link) state_reg == LDS_RACK && scl_fall);
    cov_restart: cover property (@(posedge clk_link) bus_busy && start_det);
endmodule

//--- test_led_driver_serial_slave_port.sv
// self-checking bench of the led driver serial slave port
`timescale 1ns/100ps
module test_led_driver_serial_slave_port;
    import lds_pkg::*;
    logic        clk_sys = 1'b0, clk_link = 1'b0, reset = 1'b1, reset_pin_n = 1'b1;
    logic        scl, sda_m, sda_o, sda_oe_n, bus_busy, rd_valid, a;
    logic [2:0]  sel = 3'h0;
    logic [7:0]  rd_data, d0, d1, d2, exp_q[$];
    logic [15:0] led_i = 16'h0000, led_oe_n, led_o;
    logic [31:0] seed = 32'd63131;
    int          n_mismatch = 0, num_checks = 0;
    // open-drain line with pull-up: low if either party pulls
    wire         sda_w = sda_m & (sda_oe_n | sda_o);
    always #20 clk_sys = ~clk_sys;
    initial
    begin
        #7.3;
        forever #80 clk_link = ~clk_link;
    end
    lds_top i_lds_top (.clk_sys(clk_sys), .reset(reset), .reset_pin_n(reset_pin_n),
        .clk_link(clk_link), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .slave_addr_sel_lsb(sel[0]), .slave_addr_sel_mid(sel[1]), .slave_addr_sel_msb(sel[2]),
        .led_i(led_i), .led_o(led_o), .led_oe_n(led_oe_n), .bus_busy(bus_busy));
    lds_i2c_master i_lds_i2c_master (.clk_sys(clk_sys), .sda_in(sda_w), .scl(scl),
        .sda(sda_m), .rd_valid(rd_valid), .rd_data(rd_data));
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task print_verdict();
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task send(input logic [7:0] b);
        i_lds_i2c_master.wbyte(b, a);
        cmp(16'(a), 16'h1);
    endtask
    task wr(input logic [7:0] ra, input logic [7:0] d[$]);
        i_lds_i2c_master.start();
        send({LDS_ADDR_FIXED, sel, 1'b0});
        send(ra);
        foreach (d[i]) send(d[i]);
        i_lds_i2c_master.stop();
    endtask
    task rd(input logic [7:0] ra, input int n);
        i_lds_i2c_master.start();
        send({LDS_ADDR_FIXED, sel, 1'b0});
        send(ra);
        i_lds_i2c_master.start();
        send({LDS_ADDR_FIXED, sel, 1'b1});
        for (int i = 0; i < n; i++) i_lds_i2c_master.rbyte(i == n - 1);
        i_lds_i2c_master.stop();
    endtask
    always @(posedge rd_valid) cmp(16'(rd_data), 16'(exp_q.pop_front()));
    initial
    begin
        repeat (95000) @(posedge clk_sys);
        n_mismatch++;
        print_verdict();
    end
    initial
    begin
        repeat (10) @(negedge clk_sys);
        reset = 1'b0;
        led_i = 16'(xs());
        sel = 3'(xs());
        d0 = 8'(xs());
        d1 = 8'(xs());
        d2 = 8'(xs());
        repeat (40) @(negedge clk_sys);
        exp_q = {exp_q, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
        rd(8'h12, 8);
        wr(8'h18, '{d0, d1, d2});
        exp_q = {exp_q, d0, d1, led_i[7:0], led_i[15:8], d2};
        rd(8'h18, 5);
        wr(8'h03, '{d1, d0});
        exp_q = {exp_q, d0, 8'h00};
        rd(8'h13, 2);
        wr(8'h01, '{~led_i[15:8]});
        exp_q.push_back(led_i[15:8]);
        rd(8'h01, 1);
        wr(8'h06, '{8'h1b});
        repeat (8) @(negedge clk_sys);
        cmp(16'(led_oe_n[3:2]), 16'h2);
        cmp(led_o, 16'h0000);
        i_lds_i2c_master.start();
        cmp(16'(bus_busy), 16'h1);
        i_lds_i2c_master.wbyte({LDS_ADDR_FIXED, ~sel, 1'b0}, a);
        cmp(16'(a), 16'h0);
        i_lds_i2c_master.stop();
        cmp(16'(bus_busy), 16'h0);
        reset_pin_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        reset_pin_n = 1'b1;
        repeat (40) @(negedge clk_sys);
        cmp(led_oe_n, 16'hffff);
        exp_q.push_back(8'h00);
        rd(8'h06, 1);
        cmp(16'(exp_q.size()), 16'h0);
        print_verdict();
    end
endmodule
